// ===== design/uirp_consts.svh
`ifndef UIRP_CONSTS_SVH
`define UIRP_CONSTS_SVH

// ****************************************************************
// Special function register addresses of the indirect port.
// ****************************************************************
`define UIRP_SFR_CTRL 8'h96
`define UIRP_SFR_DATA 8'h97

// ****************************************************************
// Control register fields and reset values.
// ****************************************************************
`define UIRP_BUSY_BIT 7
`define UIRP_AUTO_BIT 6
`define UIRP_CTRL_RST 8'h00
`define UIRP_DATA_RST 8'h00
`define UIRP_CLOCK_RECOVERY_CONTROL_RST 8'h09
`define UIRP_ZERO_BYTE 8'h00

// ****************************************************************
// Indirect address map.
// ****************************************************************
`define UIRP_UA_FUNC_ADDR 6'h00
`define UIRP_UA_POWER_MGMT 6'h01
`define UIRP_UA_IN_FLAGS 6'h02
`define UIRP_UA_OUT_FLAGS 6'h04
`define UIRP_UA_COMMON_FLAGS 6'h06
`define UIRP_UA_IN_ENABLES 6'h07
`define UIRP_UA_OUT_ENABLES 6'h09
`define UIRP_UA_COMMON_ENABLES 6'h0B
`define UIRP_UA_FRAME_LOW 6'h0C
`define UIRP_UA_FRAME_HIGH 6'h0D
`define UIRP_UA_EP_INDEX 6'h0E
`define UIRP_UA_CLK_RECOVERY 6'h0F
`define UIRP_UA_EP_CSR 6'h11
`define UIRP_UA_IN_CSR_HIGH 6'h12
`define UIRP_UA_OUT_CSR_LOW 6'h14
`define UIRP_UA_OUT_CSR_HIGH 6'h15
`define UIRP_UA_EP_COUNT 6'h16
`define UIRP_UA_OUT_COUNT_HIGH 6'h17
`define UIRP_UA_IDX_BASE 6'h11
`define UIRP_UA_IDX_TOP 6'h17

`endif

// ===== design/uirp_ep_mem.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Per-endpoint indexed register storage with registered read data.
// ****************************************************************
module uirp_ep_mem #(
    parameter int DW = 8,
    parameter int AW = 5
) (
    input wire logic clock_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic re_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);

    logic [DW-1:0] mem_q [0:(1<<AW)-1];
    logic [DW-1:0] rdata_q;

    always_ff @(posedge clock_i)
    begin
        if (we_i)
        begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (re_i)
        begin
            rdata_q <= mem_q[raddr_i];
        end
    end

    assign rdata_o = rdata_q;

endmodule

`default_nettype wire

// ===== design/uirp_flags.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Sticky event flags, cleared by an indirect read; a set wins.
// ****************************************************************
module uirp_flags #(
    parameter int W = 8
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] set_i,
    input wire logic clr_i,
    output logic [W-1:0] flags_o
);

    logic [W-1:0] flag_q;

    for (genvar i = 0; i < W; i++)
    begin : g_bit
        always_ff @(posedge clock_i or posedge sys_rst_i)
        begin
            if (sys_rst_i)
            begin
                flag_q[i] <= 1'b0;
            end
            else
            begin
                flag_q[i] <= set_i[i] | (flag_q[i] & ~clr_i);
            end
        end
    end

    assign flags_o = flag_q;

endmodule

`default_nettype wire

// ===== design/uirp_pkg.sv
package uirp_pkg;

    typedef logic [7:0] uirp_byte_t;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_ISSUE,
        RD_LOAD
    } uirp_rd_state_e;

endpackage

// ===== design/uirp_port.sv
`timescale 1ns/1ps
`default_nettype none

`include "uirp_consts.svh"

// Functional notes
// - USB registers reached only through two SFRs.
// - Six-bit target address selects the register.
// - Indexed addresses route to the selected endpoint.
// - Data SFR carries write and read data.
// - Flags decoded at 0x02, 0x04, 0x06.
// - Enables decoded at 0x07, 0x09, 0x0B.
// - Frame number low 0x0C, high 0x0D.
// - Index zero: control 0x11, count 0x16.
// - IN high 0x12, OUT low 0x14, high 0x15.
// - OUT packet count high byte at 0x17.
// - 0x02 to 0x0B form flag/enable group.
module uirp_port #(
    parameter int EP_W = 2
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire uirp_pkg::uirp_byte_t sfr_wdata_i,
    output uirp_pkg::uirp_byte_t sfr_rdata_o,
    input wire logic usb_clk_ok_i,
    input wire logic [7:0] in_evt_i,
    input wire logic [7:0] out_evt_i,
    input wire logic [7:0] common_evt_i,
    input wire logic [10:0] frame_num_i,
    input wire logic core_we_i,
    input wire logic [EP_W-1:0] core_ep_i,
    input wire logic [2:0] core_slot_i,
    input wire uirp_pkg::uirp_byte_t core_wdata_i,
    output uirp_pkg::uirp_byte_t function_address_o,
    output uirp_pkg::uirp_byte_t power_mgmt_o,
    output uirp_pkg::uirp_byte_t endpoint_index_o,
    output uirp_pkg::uirp_byte_t clk_recovery_o,
    output uirp_pkg::uirp_byte_t in_enables_o,
    output uirp_pkg::uirp_byte_t out_enables_o,
    output uirp_pkg::uirp_byte_t common_enables_o,
    output logic busy_o
);

    import uirp_pkg::*;
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);

    // ****************************************************************
    // Decode helpers.
    // ****************************************************************
    function automatic logic is_indexed(input logic [5:0] a);
        is_indexed = (a >= `UIRP_UA_IDX_BASE) && (a <= `UIRP_UA_IDX_TOP);
    endfunction

    function automatic logic is_sw_writable_idx(input logic [5:0] a);
        is_sw_writable_idx = (a == `UIRP_UA_EP_CSR)
            || (a == `UIRP_UA_IN_CSR_HIGH)
            || (a == `UIRP_UA_OUT_CSR_LOW)
            || (a == `UIRP_UA_OUT_CSR_HIGH);
    endfunction

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    uirp_byte_t ctrl_q, data_q, rdata_q, func_addr_q, power_q;
    uirp_byte_t index_q, clock_recovery_control_q, in_ie_q, out_ie_q, cm_ie_q;
    uirp_rd_state_e rd_state_q;
    logic [5:0] target_addr;
    logic auto_reread_bit, ctrl_wr, data_wr, data_rd, start_rd, load;
    logic sw_common_wr, sw_idx_wr, mem_we;
    logic [EP_W+2:0] mem_waddr;
    uirp_byte_t mem_wdata, mem_rdata, common_rdata;
    logic [7:0] in_flags, out_flags, cm_flags;

    // ****************************************************************
    // Special function register decode.
    // ****************************************************************
    assign ctrl_wr = sfr_wr_i && (sfr_addr_i == `UIRP_SFR_CTRL);
    assign data_wr = sfr_wr_i && (sfr_addr_i == `UIRP_SFR_DATA);
    assign data_rd = sfr_rd_i && (sfr_addr_i == `UIRP_SFR_DATA);
    assign target_addr = ctrl_q[5:0];
    assign auto_reread_bit = ctrl_q[`UIRP_AUTO_BIT];
    assign busy_o = ctrl_q[`UIRP_BUSY_BIT];
    assign load = (rd_state_q == RD_LOAD);

    // A write of zero to busy has no effect; reads are ignored while busy.
    assign start_rd = (rd_state_q == RD_IDLE)
        && ((ctrl_wr && sfr_wdata_i[`UIRP_BUSY_BIT])
        || (data_rd && auto_reread_bit));

    // ****************************************************************
    // Address/control register; busy drops once the data is loaded.
    // ****************************************************************
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_q <= `UIRP_CTRL_RST;
        end
        else
        begin
            if (ctrl_wr)
            begin
                ctrl_q[6:0] <= sfr_wdata_i[6:0];
            end
            if (start_rd)
            begin
                ctrl_q[`UIRP_BUSY_BIT] <= 1'b1;
            end
            else if (load)
            begin
                ctrl_q[`UIRP_BUSY_BIT] <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Indirect read sequencer.
    // ****************************************************************
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rd_state_q <= RD_IDLE;
        end
        else
        begin
            case (rd_state_q)
                RD_IDLE:
                begin
                    if (start_rd)
                        rd_state_q <= RD_ISSUE;
                end
                RD_ISSUE:
                begin
                    // Waits for the USB clock before touching its registers.
                    if (usb_clk_ok_i)
                        rd_state_q <= RD_LOAD;
                end
                RD_LOAD: rd_state_q <= RD_IDLE;
                default: rd_state_q <= RD_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Read mux of the common and interrupt registers.
    // ****************************************************************
    always_comb
    begin
        case (target_addr)
            `UIRP_UA_FUNC_ADDR: common_rdata = func_addr_q;
            `UIRP_UA_POWER_MGMT: common_rdata = power_q;
            `UIRP_UA_IN_FLAGS: common_rdata = in_flags;
            `UIRP_UA_OUT_FLAGS: common_rdata = out_flags;
            `UIRP_UA_COMMON_FLAGS: common_rdata = cm_flags;
            `UIRP_UA_IN_ENABLES: common_rdata = in_ie_q;
            `UIRP_UA_OUT_ENABLES: common_rdata = out_ie_q;
            `UIRP_UA_COMMON_ENABLES: common_rdata = cm_ie_q;
            `UIRP_UA_FRAME_LOW: common_rdata = frame_num_i[7:0];
            `UIRP_UA_FRAME_HIGH: common_rdata = {5'h00, frame_num_i[10:8]};
            `UIRP_UA_EP_INDEX: common_rdata = index_q;
            `UIRP_UA_CLK_RECOVERY: common_rdata = clock_recovery_control_q;
            default: common_rdata = `UIRP_ZERO_BYTE;
        endcase
    end

    // ****************************************************************
    // Data register: write data in, loaded read data out.
    // ****************************************************************
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            data_q <= `UIRP_DATA_RST;
        end
        else if (load)
        begin
            data_q <= is_indexed(target_addr) ? mem_rdata : common_rdata;
        end
        else if (data_wr)
        begin
            data_q <= sfr_wdata_i;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rdata_q <= `UIRP_ZERO_BYTE;
        end
        else if (sfr_rd_i)
        begin
            case (sfr_addr_i)
                `UIRP_SFR_CTRL: rdata_q <= ctrl_q;
                `UIRP_SFR_DATA: rdata_q <= data_q;
                default: rdata_q <= `UIRP_ZERO_BYTE;
            endcase
        end
    end

    assign sfr_rdata_o = rdata_q;

    // ****************************************************************
    // Common register writes through the data register.
    // ****************************************************************
    assign sw_common_wr = data_wr && !is_indexed(target_addr);
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            func_addr_q <= `UIRP_ZERO_BYTE;
            power_q <= `UIRP_ZERO_BYTE;
            index_q <= `UIRP_ZERO_BYTE;
            clock_recovery_control_q <= `UIRP_CLOCK_RECOVERY_CONTROL_RST;
            in_ie_q <= `UIRP_ZERO_BYTE;
            out_ie_q <= `UIRP_ZERO_BYTE;
            cm_ie_q <= `UIRP_ZERO_BYTE;
        end
        else if (sw_common_wr)
        begin
            case (target_addr)
                `UIRP_UA_FUNC_ADDR: func_addr_q <= sfr_wdata_i;
                `UIRP_UA_POWER_MGMT: power_q <= sfr_wdata_i;
                `UIRP_UA_EP_INDEX: index_q <= sfr_wdata_i;
                `UIRP_UA_CLK_RECOVERY: clock_recovery_control_q <= sfr_wdata_i;
                `UIRP_UA_IN_ENABLES: in_ie_q <= sfr_wdata_i;
                `UIRP_UA_OUT_ENABLES: out_ie_q <= sfr_wdata_i;
                `UIRP_UA_COMMON_ENABLES: cm_ie_q <= sfr_wdata_i;
                default:
                begin
                end
            endcase
        end
    end

    assign function_address_o = func_addr_q;
    assign power_mgmt_o = power_q;
    assign endpoint_index_o = index_q;
    assign clk_recovery_o = clock_recovery_control_q;
    assign in_enables_o = in_ie_q;
    assign out_enables_o = out_ie_q;
    assign common_enables_o = cm_ie_q;

    // ****************************************************************
    // Interrupt flags, cleared when an indirect read loads them.
    // ****************************************************************
    uirp_flags #(.W(8)) u_in_flags (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .set_i(in_evt_i),
        .clr_i(load && (target_addr == `UIRP_UA_IN_FLAGS)),
        .flags_o(in_flags)
    );
    uirp_flags #(.W(8)) u_out_flags (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .set_i(out_evt_i),
        .clr_i(load && (target_addr == `UIRP_UA_OUT_FLAGS)),
        .flags_o(out_flags)
    );
    uirp_flags #(.W(8)) u_cm_flags (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .set_i(common_evt_i),
        .clr_i(load && (target_addr == `UIRP_UA_COMMON_FLAGS)),
        .flags_o(cm_flags)
    );

    // ****************************************************************
    // Indexed registers; slot is the low three address bits.
    // ****************************************************************
    // Core updates take priority; counts are read-only to software.
    assign sw_idx_wr = data_wr && is_sw_writable_idx(target_addr);
    assign mem_we = core_we_i || sw_idx_wr;
    assign mem_waddr = core_we_i ? {core_ep_i, core_slot_i}
        : {index_q[EP_W-1:0], target_addr[2:0]};
    assign mem_wdata = core_we_i ? core_wdata_i : sfr_wdata_i;

    uirp_ep_mem #(.DW(8), .AW(EP_W + 3)) u_ep_mem (
        .clock_i(clock_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .re_i((rd_state_q == RD_ISSUE) && usb_clk_ok_i),
        .raddr_i({index_q[EP_W-1:0], target_addr[2:0]}),
        .rdata_o(mem_rdata)
    );

    // ****************************************************************
    // Checks.
    // ****************************************************************
    AST_BUSY_SET: assert property (
        (rd_state_q == RD_IDLE && ctrl_wr && sfr_wdata_i[7]) |=> busy_o)
        else $error("busy not set by write of one");
    AST_BUSY_WAIT: assert property (
        (rd_state_q == RD_ISSUE && !usb_clk_ok_i) |=> busy_o)
        else $error("busy dropped without usb clock");
    AST_BUSY_DONE: assert property (
        (rd_state_q == RD_ISSUE && usb_clk_ok_i) |=> busy_o ##1 !busy_o)
        else $error("busy did not clear two cycles after issue");
    AST_AUTO_READ: assert property (
        (rd_state_q == RD_IDLE && data_rd && auto_reread_bit)
        |=> (rd_state_q == RD_ISSUE) && busy_o)
        else $error("auto reread not started");
    AST_NO_AUTO: assert property (
        (rd_state_q == RD_IDLE && data_rd && !auto_reread_bit && !ctrl_wr)
        |=> !busy_o)
        else $error("read started without auto bit");
    AST_DATA_WRITE: assert property (
        (data_wr && !load) |=> data_q == $past(sfr_wdata_i))
        else $error("data register did not take write data");
    AST_TARGET: assert property (
        ctrl_wr |=> target_addr == $past(sfr_wdata_i[5:0]))
        else $error("target address not stored");
    AST_ROUTE: assert property (
        (sw_idx_wr && !core_we_i) |=> u_ep_mem.mem_q[
        {$past(index_q[EP_W-1:0]), $past(target_addr[2:0])}]
        == $past(sfr_wdata_i))
        else $error("indexed write not routed to selected endpoint");
    AST_FRAME_LOW: assert property (
        (load && target_addr == `UIRP_UA_FRAME_LOW)
        |=> data_q == $past(frame_num_i[7:0]))
        else $error("frame low byte not loaded");
    AST_FLAG_CLEAR: assert property (
        (load && target_addr == `UIRP_UA_IN_FLAGS && in_evt_i == 8'h00)
        |=> in_flags == 8'h00)
        else $error("in flags not cleared by read");

endmodule

`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import uirp_pkg::*;

    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] sfr_addr_i;
    logic sfr_wr_i;
    logic sfr_rd_i;
    uirp_byte_t sfr_wdata_i;
    uirp_byte_t sfr_rdata_o;
    logic usb_clk_ok_i = 1'b1;
    logic [7:0] in_evt_i = 8'h00;
    logic [7:0] out_evt_i = 8'h00;
    logic [7:0] common_evt_i = 8'h00;
    logic [10:0] frame_num_i = 11'h000;
    logic core_we_i = 1'b0;
    logic [1:0] core_ep_i = 2'h0;
    logic [2:0] core_slot_i = 3'h0;
    uirp_byte_t core_wdata_i = 8'h00;
    uirp_byte_t fa_o, pm_o, ix_o, cr_o, ie_o, oe_o, ce_o;
    logic busy_o;
    int error_cnt = 0;
    int tests_run = 0;
    uirp_byte_t exp_q[$];
    string name_q[$];
    logic [5:0] com_a [6] = '{6'h00, 6'h01, 6'h07, 6'h09, 6'h0B, 6'h0F};
    logic [5:0] fl_a [3] = '{6'h02, 6'h04, 6'h06};
    logic [2:0] sw_s [4] = '{3'h1, 3'h2, 3'h4, 3'h5};
    uirp_byte_t sh [6];
    uirp_byte_t ev [3];
    uirp_byte_t mem [4][8];
    int i, j, n;

    always #4 clock_i = ~clock_i;

    uirp_core_model core (.clock_i(clock_i), .busy_i(busy_o),
        .sfr_addr_o(sfr_addr_i), .sfr_wr_o(sfr_wr_i),
        .sfr_rd_o(sfr_rd_i), .sfr_wdata_o(sfr_wdata_i));

    uirp_port #(.EP_W(2)) uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .usb_clk_ok_i(usb_clk_ok_i),
        .in_evt_i(in_evt_i), .out_evt_i(out_evt_i),
        .common_evt_i(common_evt_i), .frame_num_i(frame_num_i),
        .core_we_i(core_we_i), .core_ep_i(core_ep_i),
        .core_slot_i(core_slot_i), .core_wdata_i(core_wdata_i),
        .function_address_o(fa_o), .power_mgmt_o(pm_o),
        .endpoint_index_o(ix_o), .clk_recovery_o(cr_o),
        .in_enables_o(ie_o), .out_enables_o(oe_o),
        .common_enables_o(ce_o), .busy_o(busy_o));

    // ****************************************************************
    // Comparison, reporting and closing.
    // ****************************************************************
    task automatic check(string what, uirp_byte_t seen, uirp_byte_t exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s exp=%h seen=%h", what, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("checks=%0d errors=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    function automatic uirp_byte_t port_of(logic [5:0] a);
        case (a)
            6'h00: return fa_o;
            6'h01: return pm_o;
            6'h07: return ie_o;
            6'h09: return oe_o;
            6'h0B: return ce_o;
            6'h0E: return ix_o;
            default: return cr_o;
        endcase
    endfunction

    // The result of each SFR read is compared at the falling edge after the read strobe is sampled.
    always @(posedge clock_i)
    begin
        if (sfr_rd_i === 1'b1)
        begin
            @(negedge clock_i);
            check(name_q.pop_front(), sfr_rdata_o, exp_q.pop_front());
        end
    end

    initial
    begin
        repeat (20000) @(posedge clock_i);
        error_cnt++;
        summarize();
    end

    // ****************************************************************
    // Bus helpers.
    // ****************************************************************
    task automatic rd(logic [7:0] a, uirp_byte_t e, string nm);
        exp_q.push_back(e);
        name_q.push_back(nm);
        core.get(a);
    endtask

    task automatic idle;
        bit ok;
        core.wait_idle(ok);
        check("busy wait", {7'h00, busy_o}, 8'h00);
    endtask

    task automatic iread(logic [5:0] a, uirp_byte_t e, string nm);
        core.put(8'h96, {2'b10, a});
        idle();
        rd(8'h97, e, nm);
    endtask

    task automatic iwrite(logic [5:0] a, uirp_byte_t d);
        core.put(8'h96, {2'b00, a});
        core.put(8'h97, d);
    endtask

    task automatic done(string nm);
        $display("test %s finished, errors so far %0d", nm, error_cnt);
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial
    begin
        void'($urandom(32'h6535));
        repeat (12) @(posedge clock_i);
        @(negedge clock_i);
        sys_rst_i = 1'b0;
        rd(8'h96, 8'h00, "ctrl reset");
        rd(8'h97, 8'h00, "data reset");
        rd(8'h95, 8'h00, "unmapped sfr");
        for (i = 0; i < 6; i++)
            check("reg reset", port_of(com_a[i]),
                (com_a[i] == 6'h0F) ? 8'h09 : 8'h00);
        for (i = 0; i < 6; i++)
        begin
            sh[i] = 8'($urandom);
            iwrite(com_a[i], sh[i]);
            check("reg port", port_of(com_a[i]), sh[i]);
            iread(com_a[i], sh[i], "reg read");
        end
        done("common");

        frame_num_i = 11'($urandom);
        iread(6'h0C, frame_num_i[7:0], "frame low");
        iread(6'h0D, {5'h00, frame_num_i[10:8]}, "frame high");
        iwrite(6'h0C, ~frame_num_i[7:0]);
        iread(6'h0C, frame_num_i[7:0], "frame read only");
        done("frame");

        for (i = 0; i < 3; i++)
            ev[i] = 8'($urandom) | 8'h01;
        in_evt_i = ev[0];
        out_evt_i = ev[1];
        common_evt_i = ev[2];
        @(negedge clock_i);
        in_evt_i = 8'h00;
        out_evt_i = 8'h00;
        common_evt_i = 8'h00;
        for (i = 0; i < 3; i++)
        begin
            iread(fl_a[i], ev[i], "flags");
            iread(fl_a[i], 8'h00, "flags cleared");
        end
        done("flags");

        core_we_i = 1'b1;
        for (i = 0; i < 8; i++)
        begin
            mem[i / 2][6 + i % 2] = 8'($urandom);
            core_ep_i = 2'(i / 2);
            core_slot_i = 3'(6 + i % 2);
            core_wdata_i = mem[i / 2][6 + i % 2];
            @(negedge clock_i);
        end
        core_we_i = 1'b0;
        for (i = 0; i < 4; i++)
        begin
            iwrite(6'h0E, 8'(i));
            for (j = 0; j < 4; j++)
            begin
                mem[i][sw_s[j]] = 8'($urandom);
                iwrite({3'h2, sw_s[j]}, mem[i][sw_s[j]]);
            end
        end
        for (i = 3; i >= 0; i--)
        begin
            iwrite(6'h0E, 8'(i));
            check("index port", ix_o, 8'(i));
            for (j = 1; j < 8; j++)
                if (j != 3)
                    iread(6'h10 | 6'(j), mem[i][j], "indexed");
        end
        iwrite(6'h16, ~mem[0][6]);
        iread(6'h16, mem[0][6], "count read only");
        iread(6'h20, 8'h00, "fifo reads zero");
        done("indexed");

        usb_clk_ok_i = 1'b0;
        core.put(8'h96, 8'h80);
        repeat (10) @(negedge clock_i);
        check("busy held", {7'h00, busy_o}, 8'h01);
        usb_clk_ok_i = 1'b1;
        idle();
        rd(8'h97, sh[0], "late read");
        core.put(8'h96, 8'h01);
        check("busy zero write", {7'h00, busy_o}, 8'h00);
        done("busy");

        core.put(8'h96, 8'hC1);
        idle();
        rd(8'h96, 8'h41, "ctrl auto");
        for (i = 0; i < 3; i++)
        begin
            rd(8'h97, sh[1], "auto read");
            n = 0;
            while (busy_o !== 1'b1 && n < 3)
            begin
                @(negedge clock_i);
                n++;
            end
            check("auto restart", {7'h00, busy_o}, 8'h01);
            idle();
        end
        core.put(8'h96, 8'h01);
        rd(8'h97, sh[1], "plain read");
        repeat (3) @(negedge clock_i);
        check("no restart", {7'h00, busy_o}, 8'h00);
        done("auto");
        summarize();
    end
endmodule

`default_nettype wire

// ===== test/uirp_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Core side of the SFR bus: one-cycle strobes launched at the
// falling edge, bus lines scrambled while no strobe is up.
// ****************************************************************
module uirp_core_model (
    input wire logic clock_i,
    input wire logic busy_i,
    output logic [7:0] sfr_addr_o,
    output logic sfr_wr_o,
    output logic sfr_rd_o,
    output uirp_pkg::uirp_byte_t sfr_wdata_o
);
    import uirp_pkg::*;

    initial
    begin
        sfr_addr_o = 8'h00;
        sfr_wr_o = 1'b0;
        sfr_rd_o = 1'b0;
        sfr_wdata_o = 8'h00;
    end

    task automatic put(input logic [7:0] a, input uirp_byte_t d);
        @(negedge clock_i);
        sfr_addr_o = a;
        sfr_wdata_o = d;
        sfr_wr_o = 1'b1;
        @(negedge clock_i);
        sfr_wr_o = 1'b0;
        sfr_wdata_o = ~d;
        sfr_addr_o = ~a;
    endtask

    task automatic get(input logic [7:0] a);
        @(negedge clock_i);
        sfr_addr_o = a;
        sfr_rd_o = 1'b1;
        @(negedge clock_i);
        sfr_rd_o = 1'b0;
        sfr_addr_o = ~a;
    endtask

    // Polls the busy flag before data is trusted, for a bounded time.
    task automatic wait_idle(output bit ok);
        int n;
        ok = 1'b0;
        for (n = 0; n < 64 && !ok; n++)
        begin
            if (busy_i === 1'b0)
                ok = 1'b1;
            else
                @(negedge clock_i);
        end
    endtask
endmodule

`default_nettype wire
